// File: xbar_pkg.sv
// Shared constants, types and state records for the crossbar routing block.
// Notes on behaviour
// [R01] Same-direction data phases return in issue order.
// [R02] Block same-direction request to other bus until done.
// [R03] Same-bus same-direction requests are never blocked; the code holds them back once that bus's queue for the direction holds five.
// [R04] Opposite-direction request to other bus may proceed.
// [R05] Blocked master skipped; best remaining requester wins.
// [R06] Arbiters share seven per-master direction busy flags.
// [R07] Master marks sync by setting attribute bit seven.
// [R08] Sync win blocks all five masters until drained.
// [R09] Sync blocking starts only after master-bus-port grant.
// [R10] Sync requester busy follows destination slave busy.
// [R11] Sync accepted from processor and fabric ports alike.
// [R12] Five masters routed to memory or master bus.
// [R13] Address is 4-bit upper plus 32-bit lower.
// [R14] Upper bits pick 2-bit field choosing route map.
// [R15] Lower address MSBs index the 32-bit route map.
// [R16] Map bit one: memory port; zero: master bus.
// [R17] Region registers writable; defaults from attribute pins.
// [R18] Software uses only route map zero.
// [R19] Fabric ports supply predecoded route flag; no decode.
// [R20] Five-deep read and write queues per bus.
// [R21] Acknowledge three cycles after request, drops likewise.
// [R22] Address bit zero is most significant.
// [R23] Region registers load defaults at reset, hold after; the code captures them on the first edge after reset is released.
`default_nettype none
package xbar_pkg;
   localparam int NUM_MASTERS = 5;
   localparam int NUM_SLAVES = 2;
   localparam int ID_W = 3;
   localparam int QUEUE_DEPTH = 5;
   localparam int CNT_W = 3;
   localparam int UADDR_W = 4;
   localparam int ADDR_W = 32;
   localparam int ATTR_W = 16;
   // Attribute bit 7 counted from the MSB, as the bus numbers it.
   localparam int SYNC_ATTR_BIT = ATTR_W - 1 - 7;
   localparam int MAP_COUNT = 4;
   localparam int SEL_FIELD_W = 2;
   localparam int MAP_INDEX_W = 5;

   localparam logic [ID_W-1:0] M_INSTR_RD = 3'h0;
   localparam logic [ID_W-1:0] M_DATA_WR = 3'h1;
   localparam logic [ID_W-1:0] M_DATA_RD = 3'h2;
   localparam logic [ID_W-1:0] M_FABRIC0 = 3'h3;
   localparam logic [ID_W-1:0] M_FABRIC1 = 3'h4;
   localparam int NUM_DECODED = 3;

   localparam int S_MEM = 0;
   localparam int S_MBUS = 1;
   localparam int BUSY_LINES = 7;

   localparam int DCR_ADDR_W = 10;
   localparam logic [DCR_ADDR_W-1:0] DCR_REGION_SELECT = 10'h020;
   localparam logic [DCR_ADDR_W-1:0] DCR_ROUTE_MAP_0 = 10'h021;
   localparam int DCR_ACK_DELAY = 3;

   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

   typedef struct packed {
      logic valid;
      logic rnw;
      logic route_select_flag;
      logic [ATTR_W-1:0] transfer_attribute;
      logic [UADDR_W-1:0] upper_address_bits;
      logic [ADDR_W-1:0] addr;
   } master_req_s;

   typedef struct packed {
      logic valid;
      logic [ID_W-1:0] master;
      logic rnw;
      logic [ATTR_W-1:0] transfer_attribute;
      logic [UADDR_W-1:0] upper_address_bits;
      logic [ADDR_W-1:0] addr;
   } slave_req_s;

   typedef struct packed {
      logic [QUEUE_DEPTH-1:0][ID_W-1:0] slot;
      logic [CNT_W-1:0] cnt;
   } queue_state_s;

   typedef struct packed {
      logic load;
      logic [DCR_ACK_DELAY-1:0] ack_pipe;
      logic [31:0] rd_data;
      logic [31:0] region_table_select;
      logic [MAP_COUNT-1:0][31:0] region_route_map;
      logic sync_act;
      logic [ID_W-1:0] sync_id;
   } xbar_state_s;
endpackage
`default_nettype wire

// File: cmd_queue.sv
// In-order queue of master numbers for outstanding data phases on one bus direction.
`timescale 1ns/1ps
`default_nettype none
module cmd_queue (
   input wire logic clk,
   input wire logic rst,
   input wire logic push,
   input wire logic [xbar_pkg::ID_W-1:0] push_id,
   input wire logic pop,
   output logic [xbar_pkg::ID_W-1:0] head_id,
   output logic full,
   output logic empty,
   output logic [xbar_pkg::NUM_MASTERS-1:0] pending
);
   xbar_pkg::queue_state_s st_q;
   xbar_pkg::queue_state_s st_d;

   always_comb begin
      st_d = st_q;
      head_id = st_q.slot[0];
      empty = (st_q.cnt == '0);
      full = (st_q.cnt == xbar_pkg::CNT_W'(xbar_pkg::QUEUE_DEPTH)); // [R20]
      pending = '0;
      for (int i = 0; i < xbar_pkg::QUEUE_DEPTH; i++) begin
         if (xbar_pkg::CNT_W'(i) < st_q.cnt) begin
            pending[st_q.slot[i]] = 1'b1;
         end
      end
      // Oldest entry leaves first, so completions map to issue order.
      if (pop && !empty) begin
         for (int i = 0; i < xbar_pkg::QUEUE_DEPTH - 1; i++) begin
            st_d.slot[i] = st_q.slot[i + 1]; // [R01]
         end
         st_d.cnt = st_q.cnt - xbar_pkg::CNT_ONE;
      end
      if (push && (!full || pop)) begin
         st_d.slot[st_d.cnt] = push_id;
         st_d.cnt = st_d.cnt + xbar_pkg::CNT_ONE;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule
`default_nettype wire

// File: route_decode.sv
// Region lookup that picks the destination bus for one decoded request address.
`timescale 1ns/1ps
`default_nettype none
module route_decode (
   input wire logic [31:0] region_table_select,
   input wire logic [xbar_pkg::MAP_COUNT-1:0][31:0] region_route_map,
   input wire logic [xbar_pkg::UADDR_W-1:0] upper_address_bits,
   input wire logic [xbar_pkg::ADDR_W-1:0] addr,
   output logic to_mem
);
   logic [xbar_pkg::SEL_FIELD_W-1:0] map_sel;
   logic [xbar_pkg::MAP_INDEX_W-1:0] map_idx;
   logic [31:0] sel_word;
   logic [31:0] map_word;

   always_comb begin
      // Field zero sits in the two most significant bits of the select word.
      sel_word = region_table_select << (upper_address_bits * xbar_pkg::SEL_FIELD_W); // [R14]
      map_sel = sel_word[31 -: xbar_pkg::SEL_FIELD_W]; // [R22]
      map_word = region_route_map[map_sel];
      map_idx = addr[xbar_pkg::ADDR_W-1 -: xbar_pkg::MAP_INDEX_W]; // [R15]
      to_mem = map_word[5'd31 - map_idx]; // [R16]
   end
endmodule
`default_nettype wire

// File: xbar_route_order.sv
// Crossbar routing, data-phase ordering, sync serialisation and region registers.
`timescale 1ns/1ps
`default_nettype none
module xbar_route_order (
   input wire logic clk,
   input wire logic rst,
   input wire xbar_pkg::master_req_s [xbar_pkg::NUM_MASTERS-1:0] m_req,
   output logic [xbar_pkg::NUM_MASTERS-1:0] m_addr_ack,
   output logic [xbar_pkg::NUM_MASTERS-1:0] m_rd_done,
   output logic [xbar_pkg::NUM_MASTERS-1:0] m_wr_done,
   output logic [xbar_pkg::NUM_MASTERS-1:0] m_busy,
   output xbar_pkg::slave_req_s [xbar_pkg::NUM_SLAVES-1:0] s_req,
   input wire logic [xbar_pkg::NUM_SLAVES-1:0] s_addr_ack,
   input wire logic [xbar_pkg::NUM_SLAVES-1:0] s_rd_comp,
   input wire logic [xbar_pkg::NUM_SLAVES-1:0] s_wr_comp,
   input wire logic [xbar_pkg::NUM_SLAVES-1:0] s_busy,
   input wire logic [31:0] attr_region_table_select,
   input wire logic [xbar_pkg::MAP_COUNT-1:0][31:0] attr_region_route_map,
   input wire logic dcr_read,
   input wire logic dcr_write,
   input wire logic [xbar_pkg::DCR_ADDR_W-1:0] dcr_abus,
   input wire logic [31:0] dcr_wr_data,
   output logic [31:0] dcr_rd_data,
   output logic dcr_ack
);
   xbar_pkg::xbar_state_s st_q;
   xbar_pkg::xbar_state_s st_d;

   logic [xbar_pkg::NUM_DECODED-1:0] decoded_to_mem;
   logic [xbar_pkg::NUM_MASTERS-1:0] dest_mbus;
   logic [xbar_pkg::NUM_SLAVES-1:0][xbar_pkg::NUM_MASTERS-1:0] rd_pend;
   logic [xbar_pkg::NUM_SLAVES-1:0][xbar_pkg::NUM_MASTERS-1:0] wr_pend;
   logic [xbar_pkg::NUM_SLAVES-1:0][xbar_pkg::ID_W-1:0] rd_head;
   logic [xbar_pkg::NUM_SLAVES-1:0][xbar_pkg::ID_W-1:0] wr_head;
   logic [xbar_pkg::NUM_SLAVES-1:0] rd_full;
   logic [xbar_pkg::NUM_SLAVES-1:0] wr_full;
   logic [xbar_pkg::NUM_SLAVES-1:0] rd_empty;
   logic [xbar_pkg::NUM_SLAVES-1:0] wr_empty;
   logic [xbar_pkg::NUM_SLAVES-1:0][xbar_pkg::BUSY_LINES-1:0] busy_lines;
   logic [xbar_pkg::NUM_SLAVES-1:0][xbar_pkg::NUM_MASTERS-1:0] eligible;
   logic [xbar_pkg::NUM_SLAVES-1:0] accept;
   logic [xbar_pkg::NUM_SLAVES-1:0] push_rd;
   logic [xbar_pkg::NUM_SLAVES-1:0] push_wr;
   logic dcr_hit;
   logic dcr_req;
   logic dcr_take;
   logic [xbar_pkg::DCR_ADDR_W-1:0] map_off;

   // Busy line position for a master and direction, shared by both arbiters.
   function automatic int busy_line(input logic [xbar_pkg::ID_W-1:0] m, input logic rnw);
      int idx;
      idx = 0;
      case (m)
         xbar_pkg::M_INSTR_RD: idx = 0;
         xbar_pkg::M_DATA_WR: idx = 1;
         xbar_pkg::M_DATA_RD: idx = 2;
         xbar_pkg::M_FABRIC0: idx = rnw ? 3 : 4;
         xbar_pkg::M_FABRIC1: idx = rnw ? 5 : 6;
         default: idx = 0;
      endcase
      return idx;
   endfunction

   // Processor ports decode their own address; fabric ports arrive predecoded.
   genvar g;
   generate
      for (g = 0; g < xbar_pkg::NUM_DECODED; g++) begin : g_dec
         route_decode u_dec (
            .region_table_select(st_q.region_table_select),
            .region_route_map(st_q.region_route_map),
            .upper_address_bits(m_req[g].upper_address_bits),
            .addr(m_req[g].addr),
            .to_mem(decoded_to_mem[g])
         ); // [R12] [R13]
      end
      for (g = 0; g < xbar_pkg::NUM_SLAVES; g++) begin : g_q
         cmd_queue u_rdq (
            .clk(clk),
            .rst(rst),
            .push(push_rd[g]),
            .push_id(s_req[g].master),
            .pop(s_rd_comp[g]),
            .head_id(rd_head[g]),
            .full(rd_full[g]),
            .empty(rd_empty[g]),
            .pending(rd_pend[g])
         ); // [R20]
         cmd_queue u_wrq (
            .clk(clk),
            .rst(rst),
            .push(push_wr[g]),
            .push_id(s_req[g].master),
            .pop(s_wr_comp[g]),
            .head_id(wr_head[g]),
            .full(wr_full[g]),
            .empty(wr_empty[g]),
            .pending(wr_pend[g])
         ); // [R20]
      end
   endgenerate

   always_comb begin
      for (int m = 0; m < xbar_pkg::NUM_MASTERS; m++) begin
         if (m < xbar_pkg::NUM_DECODED) begin
            dest_mbus[m] = !decoded_to_mem[m]; // [R16]
         end else begin
            dest_mbus[m] = !m_req[m].route_select_flag; // [R19]
         end
      end
   end

   // Seven busy lines per arbiter: processor fetch, data write, data read,
   // then read and write for each fabric port.
   always_comb begin
      for (int s = 0; s < xbar_pkg::NUM_SLAVES; s++) begin
         busy_lines[s][0] = rd_pend[s][xbar_pkg::M_INSTR_RD];
         busy_lines[s][1] = wr_pend[s][xbar_pkg::M_DATA_WR];
         busy_lines[s][2] = rd_pend[s][xbar_pkg::M_DATA_RD];
         busy_lines[s][3] = rd_pend[s][xbar_pkg::M_FABRIC0];
         busy_lines[s][4] = wr_pend[s][xbar_pkg::M_FABRIC0];
         busy_lines[s][5] = rd_pend[s][xbar_pkg::M_FABRIC1];
         busy_lines[s][6] = wr_pend[s][xbar_pkg::M_FABRIC1]; // [R06]
      end
   end

   // Eligibility and fixed-order arbitration per bus.
   always_comb begin
      eligible = '0;
      s_req = '0;
      for (int s = 0; s < xbar_pkg::NUM_SLAVES; s++) begin
         for (int m = 0; m < xbar_pkg::NUM_MASTERS; m++) begin
            // Of the busy lines, only the other bus's line for this direction holds a master back;
            // same-bus work in that direction holds it back only once that queue is full.
            eligible[s][m] = m_req[m].valid
               && (dest_mbus[m] == (s == xbar_pkg::S_MBUS))
               && !busy_lines[1 - s][busy_line(xbar_pkg::ID_W'(m), m_req[m].rnw)] // [R02] [R03] [R04]
               && !(m_req[m].rnw ? rd_full[s] : wr_full[s])
               && !st_q.sync_act; // [R08]
         end
         // Lowest-numbered eligible master wins; held-back masters are skipped.
         for (int m = xbar_pkg::NUM_MASTERS - 1; m >= 0; m--) begin
            if (eligible[s][m]) begin
               s_req[s].valid = 1'b1;
               s_req[s].master = xbar_pkg::ID_W'(m);
               s_req[s].rnw = m_req[m].rnw;
               s_req[s].transfer_attribute = m_req[m].transfer_attribute;
               s_req[s].upper_address_bits = m_req[m].upper_address_bits;
               s_req[s].addr = m_req[m].addr; // [R05] [R12]
            end
         end
      end
   end

   always_comb begin
      accept = '0;
      push_rd = '0;
      push_wr = '0;
      m_addr_ack = '0;
      for (int s = 0; s < xbar_pkg::NUM_SLAVES; s++) begin
         accept[s] = s_req[s].valid && s_addr_ack[s];
         push_rd[s] = accept[s] && s_req[s].rnw;
         push_wr[s] = accept[s] && !s_req[s].rnw;
         if (accept[s]) begin
            m_addr_ack[s_req[s].master] = 1'b1;
         end
      end
   end

   // Data phase completions go back to the oldest issuer of that direction.
   always_comb begin
      m_rd_done = '0;
      m_wr_done = '0;
      for (int s = 0; s < xbar_pkg::NUM_SLAVES; s++) begin
         if (s_rd_comp[s] && !rd_empty[s]) begin
            m_rd_done[rd_head[s]] = 1'b1; // [R01]
         end
         if (s_wr_comp[s] && !wr_empty[s]) begin
            m_wr_done[wr_head[s]] = 1'b1; // [R01]
         end
      end
   end

   // Busy to each master covers its outstanding work, and for a sync
   // requester also the destination slave's own busy.
   always_comb begin
      for (int m = 0; m < xbar_pkg::NUM_MASTERS; m++) begin
         m_busy[m] = rd_pend[xbar_pkg::S_MEM][m] || wr_pend[xbar_pkg::S_MEM][m]
            || rd_pend[xbar_pkg::S_MBUS][m] || wr_pend[xbar_pkg::S_MBUS][m]
            || (st_q.sync_act && st_q.sync_id == xbar_pkg::ID_W'(m)
                && s_busy[xbar_pkg::S_MBUS]); // [R10]
      end
   end

   // Configuration port decode.
   always_comb begin
      map_off = dcr_abus - xbar_pkg::DCR_ROUTE_MAP_0;
      dcr_hit = (dcr_abus == xbar_pkg::DCR_REGION_SELECT)
         || (dcr_abus >= xbar_pkg::DCR_ROUTE_MAP_0
             && map_off < xbar_pkg::DCR_ADDR_W'(xbar_pkg::MAP_COUNT));
      dcr_req = (dcr_read || dcr_write) && dcr_hit;
      dcr_take = st_q.ack_pipe[xbar_pkg::DCR_ACK_DELAY-2]
         && !st_q.ack_pipe[xbar_pkg::DCR_ACK_DELAY-1];
      dcr_ack = st_q.ack_pipe[xbar_pkg::DCR_ACK_DELAY-1]; // [R21]
      dcr_rd_data = st_q.rd_data;
   end

   always_comb begin
      st_d = st_q;
      st_d.ack_pipe = {st_q.ack_pipe[xbar_pkg::DCR_ACK_DELAY-2:0], dcr_req}; // [R21]
      // Straps are captured on the first edge after reset is released.
      if (st_q.load) begin
         st_d.load = 1'b0;
         st_d.region_table_select = attr_region_table_select;
         st_d.region_route_map = attr_region_route_map; // [R17] [R23]
      end else if (dcr_take) begin
         if (dcr_write) begin
            if (dcr_abus == xbar_pkg::DCR_REGION_SELECT) begin
               st_d.region_table_select = dcr_wr_data; // [R17] [R18]
            end else begin
               st_d.region_route_map[map_off[1:0]] = dcr_wr_data; // [R17]
            end
         end
         if (dcr_read) begin
            if (dcr_abus == xbar_pkg::DCR_REGION_SELECT) begin
               st_d.rd_data = st_q.region_table_select;
            end else begin
               st_d.rd_data = st_q.region_route_map[map_off[1:0]];
            end
         end
      end
      if (!dcr_req) begin
         st_d.rd_data = xbar_pkg::ZERO_WORD;
      end
      // Sync serialisation: armed only by acceptance on the master bus port,
      // released once that bus has drained and its slave stops reporting busy.
      if (st_q.sync_act) begin
         if (rd_empty[xbar_pkg::S_MBUS] && wr_empty[xbar_pkg::S_MBUS]
             && !s_busy[xbar_pkg::S_MBUS]) begin
            st_d.sync_act = 1'b0; // [R08] [R10]
         end
      end else if (accept[xbar_pkg::S_MBUS]
                   && s_req[xbar_pkg::S_MBUS].transfer_attribute[xbar_pkg::SYNC_ATTR_BIT]) begin
         st_d.sync_act = 1'b1; // [R07] [R09] [R11]
         st_d.sync_id = s_req[xbar_pkg::S_MBUS].master;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
         st_q.load <= 1'b1; // [R23]
      end else begin
         st_q <= st_d;
      end
   end
endmodule
`default_nettype wire

// File: slave_model.sv
// Behavioural model of the memory and master bus slaves facing the crossbar.
`timescale 1ns/1ps
`default_nettype none
module slave_model (
   input wire logic clk,
   input wire logic rst,
   input wire xbar_pkg::slave_req_s [1:0] s_req,
   input wire logic [1:0] comp_en,
   input wire logic [1:0] busy_in,
   output logic [1:0] s_addr_ack,
   output logic [1:0] s_rd_comp,
   output logic [1:0] s_wr_comp,
   output logic [1:0] s_busy
);
   logic [1:0][3:0] rd_n_q;
   logic [1:0][3:0] wr_n_q;
   // Accepts every request at once and completes one read and one write phase per cycle per bus while enabled.
   always_comb begin
      for (int b = 0; b < 2; b++) begin
         s_addr_ack[b] = s_req[b].valid;
         s_rd_comp[b] = comp_en[b] & (rd_n_q[b] != 4'h0);
         s_wr_comp[b] = comp_en[b] & (wr_n_q[b] != 4'h0);
      end
   end
   assign s_busy = busy_in;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_n_q <= '0;
         wr_n_q <= '0;
      end else begin
         for (int b = 0; b < 2; b++) begin
            rd_n_q[b] <= rd_n_q[b] + 4'(s_addr_ack[b] & s_req[b].rnw) - 4'(s_rd_comp[b]);
            wr_n_q[b] <= wr_n_q[b] + 4'(s_addr_ack[b] & ~s_req[b].rnw) - 4'(s_wr_comp[b]);
         end
      end
   end
endmodule
`default_nettype wire

// File: xbar_route_order_chk.sv
// Concurrent checks on the ports of the crossbar routing block.
`timescale 1ns/1ps
`default_nettype none
module xbar_route_order_chk (
   input wire logic clk,
   input wire logic rst,
   input wire xbar_pkg::master_req_s [xbar_pkg::NUM_MASTERS-1:0] m_req,
   input wire logic [xbar_pkg::NUM_MASTERS-1:0] m_addr_ack,
   input wire logic [xbar_pkg::NUM_MASTERS-1:0] m_rd_done,
   input wire logic [xbar_pkg::NUM_MASTERS-1:0] m_busy,
   input wire xbar_pkg::slave_req_s [xbar_pkg::NUM_SLAVES-1:0] s_req,
   input wire logic [xbar_pkg::NUM_SLAVES-1:0] s_addr_ack,
   input wire logic [xbar_pkg::NUM_SLAVES-1:0] s_rd_comp,
   input wire logic [xbar_pkg::NUM_SLAVES-1:0] s_busy,
   input wire logic dcr_read,
   input wire logic dcr_write,
   input wire logic [xbar_pkg::DCR_ADDR_W-1:0] dcr_abus,
   input wire logic [31:0] dcr_rd_data,
   input wire logic dcr_ack
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic map_req;
   logic sync_acc;
   logic sync_q;
   logic [2:0] own_q;
   logic [4:0][3:0] rcnt_q;
   logic [4:0] rbus_q;
   assign map_req = (dcr_read | dcr_write) && dcr_abus >= 10'h020 && dcr_abus <= 10'h024;
   assign sync_acc = s_req[1].valid && s_addr_ack[1] && s_req[1].transfer_attribute[8];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_q <= 1'b0;
         own_q <= 3'h0;
         rcnt_q <= '0;
         rbus_q <= '0;
      end else begin
         sync_q <= sync_acc | (sync_q & s_busy[1]);
         if (sync_acc) begin
            own_q <= s_req[1].master;
         end
         for (int i = 0; i < 5; i++) begin
            rcnt_q[i] <= rcnt_q[i] + 4'(m_addr_ack[i] & m_req[i].rnw) - 4'(m_rd_done[i]);
            if (m_addr_ack[i] & m_req[i].rnw) begin
               rbus_q[i] <= s_req[1].valid && s_req[1].master == 3'(i) && s_addr_ack[1];
            end
         end
      end
   end
   for (genvar i = 0; i < 5; i++) begin : g_m
      a_ack_from_slave: assert property (m_addr_ack[i] |->
         (s_addr_ack[0] && s_req[0].valid && s_req[0].master == i) ||
         (s_addr_ack[1] && s_req[1].valid && s_req[1].master == i)) else $error("stray ack");
      a_rd_done_src: assert property (m_rd_done[i] |-> |s_rd_comp)
         else $error("read done without slave completion");
      a_ord_rd_bus: assert property (s_req[1].valid && s_req[1].rnw &&
         s_req[1].master == i && rcnt_q[i] != 4'h0 |-> rbus_q[i]) else $error("read split");
   end
   a_fabric_mem: assert property (s_req[0].valid && s_req[0].master >= 3'h3 |->
      m_req[s_req[0].master].route_select_flag) else $error("fabric flag ignored on memory bus");
   a_fabric_mbus: assert property (s_req[1].valid && s_req[1].master >= 3'h3 |->
      !m_req[s_req[1].master].route_select_flag) else $error("fabric flag ignored on master bus");
   a_sync_block: assert property (sync_acc |=> !s_req[0].valid && !s_req[1].valid)
      else $error("request passed during sync");
   a_sync_busy: assert property (sync_q && s_busy[1] |-> m_busy[own_q])
      else $error("sync owner busy dropped");
   a_dcr_ack_rise: assert property ($rose(map_req) |-> ##1 !dcr_ack [*2] ##1 dcr_ack)
      else $error("ack rise timing");
   a_dcr_ack_fall: assert property ($fell(map_req) |-> dcr_ack [*3] ##1 !dcr_ack)
      else $error("ack fall timing");
   a_rd_zero: assert property (!(dcr_read | dcr_write) ##1 !(dcr_read | dcr_write) |->
      dcr_rd_data == 32'h0000_0000) else $error("read data not cleared");
   c_sync: cover property (sync_acc);
   c_dcr: cover property ($rose(map_req));
   c_fabric: cover property (s_req[0].valid && s_req[0].master >= 3'h3);
endmodule
`default_nettype wire

// File: tb_crossbar_order_sync_addrmap.sv
// Self-checking testbench for the crossbar routing, ordering and sync block.
`timescale 1ns/1ps
`default_nettype none
module tb_crossbar_order_sync_addrmap;
   localparam logic [31:0] sel_strap = 32'h1000_0000;
   localparam logic [3:0][31:0] map_strap = {32'h0000_0000, 32'h0000_0000, 32'h8000_0000,
      32'h0000_000F};
   logic clk;
   logic rst;
   xbar_pkg::master_req_s [4:0] m_req;
   logic [4:0] m_addr_ack;
   logic [4:0] m_rd_done;
   logic [4:0] m_wr_done;
   logic [4:0] m_busy;
   xbar_pkg::slave_req_s [1:0] s_req;
   logic [1:0] s_addr_ack;
   logic [1:0] s_rd_comp;
   logic [1:0] s_wr_comp;
   logic [1:0] s_busy;
   logic [1:0] comp_en;
   logic [1:0] busy_in;
   logic dcr_read;
   logic dcr_write;
   logic [9:0] dcr_abus;
   logic [31:0] dcr_wr_data;
   logic [31:0] dcr_rd_data;
   logic dcr_ack;
   int n_errors;
   int checked;
   int cyc;
   xbar_route_order xbar_route_order_inst (.clk(clk), .rst(rst), .m_req(m_req),
      .m_addr_ack(m_addr_ack), .m_rd_done(m_rd_done), .m_wr_done(m_wr_done), .m_busy(m_busy),
      .s_req(s_req), .s_addr_ack(s_addr_ack), .s_rd_comp(s_rd_comp), .s_wr_comp(s_wr_comp),
      .s_busy(s_busy), .attr_region_table_select(sel_strap), .attr_region_route_map(map_strap),
      .dcr_read(dcr_read), .dcr_write(dcr_write), .dcr_abus(dcr_abus),
      .dcr_wr_data(dcr_wr_data), .dcr_rd_data(dcr_rd_data), .dcr_ack(dcr_ack));
   slave_model slave_model_inst (.clk(clk), .rst(rst), .s_req(s_req), .comp_en(comp_en),
      .busy_in(busy_in), .s_addr_ack(s_addr_ack), .s_rd_comp(s_rd_comp),
      .s_wr_comp(s_wr_comp), .s_busy(s_busy));
   task automatic end_sim();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic put(input int m, input logic rnw, input logic sy, input logic fl,
      input logic [3:0] ua, input logic [31:0] a);
      @(negedge clk);
      m_req[m] = {1'b1, rnw, fl, sy ? 16'h0100 : 16'h0000, ua, a};
   endtask
   task automatic take(input int m, input int bus);
      for (int k = 0; k < 40; k++) begin
         #1;
         if (m_addr_ack[m] === 1'b1) break;
         @(negedge clk);
      end
      chk(32'(s_req[bus].valid && s_req[bus].master == 3'(m) && m_addr_ack[m]), 32'h1);
      @(negedge clk);
      m_req[m].valid = 1'b0;
   endtask
   task automatic held(input int m, input int n);
      repeat (n) begin
         #1;
         chk(32'(m_addr_ack[m] || (s_req[0].valid && s_req[0].master == 3'(m)) ||
            (s_req[1].valid && s_req[1].master == 3'(m))), 32'h0);
         @(negedge clk);
      end
   endtask
   task automatic dcr(input logic wr, input logic [9:0] a, input logic [31:0] d,
      output logic [31:0] q, output int k);
      @(negedge clk);
      dcr_abus = a;
      dcr_wr_data = d;
      dcr_write = wr;
      dcr_read = !wr;
      for (k = 1; k < 8; k++) begin
         @(negedge clk);
         if (dcr_ack === 1'b1) break;
      end
      q = dcr_rd_data;
      dcr_read = 1'b0;
      dcr_write = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   task automatic t_regs();
      logic [31:0] q;
      int k;
      dcr(1'b0, 10'h020, 32'h0000_0000, q, k);
      chk(q, sel_strap);
      chk(32'(k), 32'h3);
      dcr(1'b1, 10'h020, 32'h0000_0000, q, k);
      dcr(1'b0, 10'h020, 32'h0000_0000, q, k);
      chk(q, 32'h0000_0000);
      dcr(1'b1, 10'h020, sel_strap, q, k);
      dcr(1'b0, 10'h022, 32'h0000_0000, q, k);
      chk(q, map_strap[1]);
      dcr(1'b1, 10'h021, 32'h0000_0400, q, k);
      chk(32'(k), 32'h3);
      dcr(1'b0, 10'h021, 32'h0000_0000, q, k);
      chk(q, 32'h0000_0400);
      put(0, 1'b1, 1'b0, 1'b0, 4'h0, 32'hABCD_9872);
      take(0, 0);
      dcr(1'b1, 10'h021, map_strap[0], q, k);
      dcr(1'b0, 10'h030, 32'h0000_0000, q, k);
      chk(32'(k), 32'h8);
      $display("t_regs done");
   endtask
   task automatic t_route();
      logic [35:0] tab [4] = '{36'h0_E923_3245, 36'h0_ABCD_9872, 36'h1_0000_0000, 36'h0_0000_0000};
      int bus [4] = '{0, 1, 0, 1};
      for (int i = 0; i < 4; i++) begin
         put(i % 3, (i % 3) != 1, 1'b0, 1'b0, tab[i][35:32], tab[i][31:0]);
         take(i % 3, bus[i]);
      end
      put(3, 1'b1, 1'b0, 1'b1, 4'h0, 32'hABCD_9872);
      take(3, 0);
      put(4, 1'b0, 1'b0, 1'b0, 4'h0, 32'hE923_3245);
      take(4, 1);
      $display("t_route done");
   endtask
   task automatic t_order();
      logic [31:0] n;
      logic [31:0] w;
      @(negedge clk);
      comp_en = 2'b00;
      repeat (5) begin
         put(3, 1'b1, 1'b0, 1'b0, 4'h0, 32'h0000_0000);
         take(3, 1);
      end
      put(3, 1'b1, 1'b0, 1'b0, 4'h0, 32'h0000_0000);
      held(3, 3);
      put(3, 1'b1, 1'b0, 1'b1, 4'h0, 32'h0000_0000);
      held(3, 3);
      put(4, 1'b1, 1'b0, 1'b1, 4'h0, 32'h0000_0000);
      take(4, 0);
      @(negedge clk);
      m_req[3].valid = 1'b0;
      put(3, 1'b0, 1'b0, 1'b1, 4'h0, 32'h0000_0000);
      take(3, 0);
      chk(32'(m_busy[3]), 32'h1);
      comp_en = 2'b11;
      n = 32'h0000_0000;
      w = 32'h0000_0000;
      repeat (12) begin
         #1;
         n = n + 32'(m_rd_done[3]);
         w = w + 32'(m_wr_done[3]);
         @(negedge clk);
      end
      chk(n, 32'h5);
      chk(w, 32'h1);
      chk(32'(m_busy[3]), 32'h0);
      put(3, 1'b1, 1'b0, 1'b1, 4'h0, 32'h0000_0000);
      take(3, 0);
      $display("t_order done");
   endtask
   task automatic t_sync();
      int m;
      for (int j = 0; j < 2; j++) begin
         m = j ? 4 : 1;
         @(negedge clk);
         busy_in = 2'b10;
         put(m, j[0], 1'b1, 1'b0, 4'h0, 32'h0000_0000);
         take(m, 1);
         put(0, 1'b1, 1'b0, 1'b0, 4'h0, 32'hE923_3245);
         held(0, 4);
         chk(32'(m_busy[m]), 32'h1);
         busy_in = 2'b00;
         take(0, 0);
         chk(32'(m_busy[m]), 32'h0);
      end
      busy_in = 2'b10;
      put(0, 1'b1, 1'b1, 1'b0, 4'h0, 32'hE923_3245);
      take(0, 0);
      put(2, 1'b1, 1'b0, 1'b0, 4'h0, 32'hE923_3245);
      take(2, 0);
      busy_in = 2'b00;
      $display("t_sync done");
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         end_sim();
      end
   end
   initial begin
      rst = 1'b1;
      m_req = '0;
      comp_en = 2'b11;
      busy_in = 2'b00;
      dcr_read = 1'b0;
      dcr_write = 1'b0;
      dcr_abus = 10'h000;
      dcr_wr_data = 32'h0000_0000;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      t_regs();
      t_route();
      t_order();
      t_sync();
      end_sim();
   end
endmodule
bind xbar_route_order xbar_route_order_chk xbar_route_order_chk_inst (.clk(clk), .rst(rst),
   .m_req(m_req), .m_addr_ack(m_addr_ack), .m_rd_done(m_rd_done), .m_busy(m_busy),
   .s_req(s_req), .s_addr_ack(s_addr_ack), .s_rd_comp(s_rd_comp), .s_busy(s_busy),
   .dcr_read(dcr_read), .dcr_write(dcr_write), .dcr_abus(dcr_abus),
   .dcr_rd_data(dcr_rd_data), .dcr_ack(dcr_ack));
`default_nettype wire
